//--- logic/cat_channel.sv
// one capture/compare channel fed by the shared counter value
`timescale 1ns/1ps
`default_nettype none
module cat_channel
  import cat_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // counter view
  input wire logic countTick,
  input wire logic [15:0] countNext,
  input wire logic [15:0] countValue,
  // setup and line
  input wire cat_chan_cfg_t cfg,
  input wire logic ioIn,
  // results
  output logic eventPulse,
  output logic ioOut,
  output logic [15:0] captureValue
);
  logic ioPrev_ff;
  logic capHit;
  logic matchHit;

  // line is synchronous; a one-cycle history is enough for edges
  always_ff @(posedge clk)
  begin
    if (srst)
      ioPrev_ff <= 1'b0;
    else
      ioPrev_ff <= ioIn;
  end

  assign capHit = (cfg.capPos & ioIn & ~ioPrev_ff) | (cfg.capNeg & ~ioIn & ioPrev_ff);
  // match is judged on the value the counter is about to take
  assign matchHit = cfg.matchEn & countTick & (countNext == cfg.compareValue);

  always_ff @(posedge clk)
  begin
    if (srst)
      captureValue <= CAT_CNT_RST;
    else if (capHit)
      captureValue <= countValue;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      eventPulse <= 1'b0;
    else
      eventPulse <= capHit | matchHit;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      ioOut <= 1'b0;
    else if (matchHit & cfg.toggleEn)
      ioOut <= ~ioOut;
  end
endmodule
`default_nettype wire

//--- logic/cat_counter_array.sv
// counter array: timebase, 16-bit counter, overflow flags, interrupt combine
// Notes on behaviour
// - free-running 16-bit counter as two bytes
// - low read snapshots high; high read returns it
// - byte reads never disturb counting
// - three-bit select picks one of seven timebases
// - oscillator timebases synchronised before use
// - wrap FFFF to 0000 sets overflow flag
// - overflow flag interrupts only when enabled
// - flag cleared only by software write zero
// - idle suspend zero keeps counting in idle
// - intermediate flag at bit 8 to 11
// - six channel flags set by channel events
// - flags set regardless of enable bits
// - request is OR of enabled flags
// - processor sees request only with both enables
// - six 16-bit channels each with I/O line
// - watchdog after reset locks configuration
`timescale 1ns/1ps
`default_nettype none
module cat_counter_array
  import cat_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // timebase sources
  input wire logic timer0Overflow,
  input wire logic externalCountInput,
  input wire logic xoscDiv8,
  input wire logic lfoDiv8,
  input wire logic cpuIdle,
  // configuration, applied on cfgLoad only while the watchdog is off; watchdogDisable acts at once
  input wire logic cfgLoad,
  input wire logic [2:0] timebaseSelect,
  input wire logic idleSuspendCtrl,
  input wire logic [1:0] cycleLengthSel,
  input wire logic watchdogDisable,
  // interrupt enables
  input wire logic overflowIrqEnable,
  input wire logic intermediateOverflowIrqEnable,
  input wire logic [5:0] channelIrqEnable,
  input wire logic globalIrqEnable,
  input wire logic counterArrayIrqEnable,
  // software clears, write-zero pulses
  input wire logic overflowFlagClear,
  input wire logic intermediateFlagClear,
  input wire logic [5:0] channelFlagClear,
  // counter byte reads
  input wire logic readLowByte,
  input wire logic readHighByte,
  // channels
  input wire cat_chan_cfg_t [5:0] channelCfg,
  input wire logic [5:0] channelIoIn,
  // outputs
  output logic [7:0] counterLowByte,
  output logic [7:0] counterHighByte,
  output logic counterOverflowFlag,
  output logic intermediateOverflowFlag,
  output logic [5:0] channelEventFlag,
  output logic [5:0] channelIoOut,
  output logic [5:0][15:0] channelCapture,
  output logic irqRequest,
  output logic cpuIrq,
  output logic watchdogActive,
  output logic watchdogReset
);
  logic [15:0] count_ff;
  logic [7:0] snapHigh_ff;
  logic [3:0] div12_ff;
  logic [1:0] div4_ff;
  logic eciPrev_ff;
  logic xoscMeta_ff;
  logic xoscSync_ff;
  logic xoscPrev_ff;
  logic lfoMeta_ff;
  logic lfoSync_ff;
  logic lfoPrev_ff;
  cat_timebase_t timebase_ff;
  logic idleSuspend_ff;
  logic [1:0] cycleLen_ff;
  logic srcTick;
  logic tick;
  logic [15:0] nxt_count;
  logic wrap16;
  logic wrapMid;
  logic [11:0] midMask;
  logic [5:0] chEvent;
  logic irqComb;

  // prescalers run freely so a timebase switch picks up mid-period
  always_ff @(posedge clk)
  begin
    if (srst)
      div12_ff <= 4'h0;
    else if (div12_ff == CAT_DIV12_LAST)
      div12_ff <= 4'h0;
    else
      div12_ff <= div12_ff + 4'h1;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      div4_ff <= 2'h0;
    else
      div4_ff <= div4_ff + 2'h1;
  end

  // external input is synchronous; only edges are needed
  always_ff @(posedge clk)
  begin
    if (srst)
      eciPrev_ff <= 1'b1;
    else
      eciPrev_ff <= externalCountInput;
  end

  // oscillator divides are asynchronous: two-flop synchronisers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      xoscMeta_ff <= 1'b0;
      xoscSync_ff <= 1'b0;
      xoscPrev_ff <= 1'b0;
      lfoMeta_ff <= 1'b0;
      lfoSync_ff <= 1'b0;
      lfoPrev_ff <= 1'b0;
    end
    else
    begin
      xoscMeta_ff <= xoscDiv8;
      xoscSync_ff <= xoscMeta_ff;
      xoscPrev_ff <= xoscSync_ff;
      lfoMeta_ff <= lfoDiv8;
      lfoSync_ff <= lfoMeta_ff;
      lfoPrev_ff <= lfoSync_ff;
    end
  end

  // configuration is frozen while the watchdog owns the array
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      timebase_ff <= TB_SYS_DIV12;
      idleSuspend_ff <= CAT_IDLE_RST;
      cycleLen_ff <= CAT_CLSEL_RST;
    end
    else if (cfgLoad & ~watchdogActive)
    begin
      timebase_ff <= cat_timebase_t'(timebaseSelect);
      idleSuspend_ff <= idleSuspendCtrl;
      cycleLen_ff <= cycleLengthSel;
    end
  end

  always_comb
  begin
    unique case (timebase_ff)
      TB_SYS_DIV12: srcTick = (div12_ff == CAT_DIV12_LAST);
      TB_SYS_DIV4: srcTick = (div4_ff == CAT_DIV4_LAST);
      TB_TMR0_OVF: srcTick = timer0Overflow;
      TB_EXT_FALL: srcTick = eciPrev_ff & ~externalCountInput;
      TB_SYS: srcTick = 1'b1;
      TB_XOSC_DIV8: srcTick = xoscSync_ff & ~xoscPrev_ff;
      TB_LFO_DIV8: srcTick = lfoSync_ff & ~lfoPrev_ff;
      TB_RESERVED: srcTick = 1'b0;
    endcase
  end

  // reads never gate the tick; only idle suspend does
  assign tick = srcTick & ~(idleSuspend_ff & cpuIdle);
  assign nxt_count = count_ff + 16'h0001;
  assign wrap16 = tick & (count_ff == CAT_CNT_MAX);
  always_comb
  begin
    unique case (cycleLen_ff)
      2'h0: midMask = 12'h0FF;
      2'h1: midMask = 12'h1FF;
      2'h2: midMask = 12'h3FF;
      2'h3: midMask = 12'h7FF;
    endcase
  end
  assign wrapMid = tick & ((count_ff[11:0] & midMask) == midMask);

  always_ff @(posedge clk)
  begin
    if (srst)
      count_ff <= CAT_CNT_RST;
    else if (tick)
      count_ff <= nxt_count;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      snapHigh_ff <= CAT_BYTE_RST;
      counterLowByte <= CAT_BYTE_RST;
      counterHighByte <= CAT_BYTE_RST;
    end
    else
    begin
      if (readLowByte)
      begin
        counterLowByte <= count_ff[7:0];
        snapHigh_ff <= count_ff[15:8];
      end
      if (readHighByte)
        counterHighByte <= snapHigh_ff;
    end
  end

  // hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (srst)
      counterOverflowFlag <= 1'b0;
    else if (wrap16)
      counterOverflowFlag <= 1'b1;
    else if (overflowFlagClear)
      counterOverflowFlag <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      intermediateOverflowFlag <= 1'b0;
    else if (wrapMid)
      intermediateOverflowFlag <= 1'b1;
    else if (intermediateFlagClear)
      intermediateOverflowFlag <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      channelEventFlag <= 6'h00;
    else
      channelEventFlag <= chEvent | (channelEventFlag & ~channelFlagClear);
  end

  for (genvar i = 0; i < CAT_NUM_CH; i++)
  begin : g_ch
    cat_channel u_ch (
      .clk(clk),
      .srst(srst),
      .countTick(tick),
      .countNext(nxt_count),
      .countValue(count_ff),
      .cfg(channelCfg[i]),
      .ioIn(channelIoIn[i]),
      .eventPulse(chEvent[i]),
      .ioOut(channelIoOut[i]),
      .captureValue(channelCapture[i])
    );
  end

  assign irqComb = (counterOverflowFlag & overflowIrqEnable)
    | (intermediateOverflowFlag & intermediateOverflowIrqEnable)
    | (|(channelEventFlag & channelIrqEnable));

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      irqRequest <= 1'b0;
      cpuIrq <= 1'b0;
    end
    else
    begin
      irqRequest <= irqComb;
      cpuIrq <= irqComb & globalIrqEnable & counterArrayIrqEnable;
    end
  end

  // channel 5 doubles as the watchdog until software turns it off
  always_ff @(posedge clk)
  begin
    if (srst)
      watchdogActive <= CAT_WDT_RST;
    else if (watchdogDisable)
      watchdogActive <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      watchdogReset <= 1'b0;
    else
      watchdogReset <= watchdogActive & chEvent[CAT_WDT_CH];
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  count_advance_a: assert property (tick |=> count_ff == $past(count_ff) + 16'h0001)
    else $error("counter did not advance on tick");
  count_hold_a: assert property (!tick |=> $stable(count_ff))
    else $error("counter moved without tick");
  snapshot_pair_a: assert property (readLowByte ##1 (readHighByte && !readLowByte) |=>
    counterHighByte == $past(count_ff[15:8], 2))
    else $error("high byte not from snapshot");
  // a timebase switch inside the gap may tick legally from the new source
  div12_rate_a: assert property (timebase_ff == TB_SYS_DIV12 && tick |=>
    (timebase_ff != TB_SYS_DIV12 || !srcTick) [*8] ##1 (timebase_ff != TB_SYS_DIV12 || !srcTick) [*3])
    else $error("divide by twelve too fast");
  ovf_set_a: assert property (tick && count_ff == CAT_CNT_MAX |=>
    counterOverflowFlag && count_ff == CAT_CNT_RST)
    else $error("wrap did not set overflow flag");
  ovf_sticky_a: assert property (counterOverflowFlag && !overflowFlagClear |=> counterOverflowFlag)
    else $error("overflow flag lost without clear");
  idle_stop_a: assert property (idleSuspend_ff && cpuIdle |=> $stable(count_ff))
    else $error("counted during suspended idle");
  idle_run_a: assert property (!idleSuspend_ff && cpuIdle && timebase_ff == TB_SYS |=> count_ff == $past(count_ff) + 16'h0001)
    else $error("idle stopped the counter");
  mid_set_a: assert property (tick && cycleLen_ff == 2'h0 && count_ff[7:0] == 8'hFF |=>
    intermediateOverflowFlag)
    else $error("intermediate flag missed");
  irq_gate_a: assert property (irqComb && !(globalIrqEnable && counterArrayIrqEnable) |=> !cpuIrq)
    else $error("interrupt passed with enables off");
  irq_ovf_a: assert property (counterOverflowFlag && overflowIrqEnable |=> irqRequest)
    else $error("enabled overflow gave no request");
  wdt_lock_a: assert property (watchdogActive && cfgLoad |=> $stable(timebase_ff))
    else $error("configuration changed under watchdog");
  chan_flag_a: assert property (|chEvent |=> (channelEventFlag & $past(chEvent)) == $past(chEvent))
    else $error("channel event lost");

  wrap_c: cover property (wrap16);
  clear_race_c: cover property (wrap16 && overflowFlagClear);
  wdt_fire_c: cover property (watchdogReset);
  ext_tick_c: cover property (timebase_ff == TB_EXT_FALL && tick);
endmodule
`default_nettype wire

//--- logic/cat_pkg.sv
// package: constants and types for the counter array timebase block
package cat_pkg;
  localparam int unsigned CAT_CNT_W = 16;
  localparam int unsigned CAT_NUM_CH = 6;
  localparam int unsigned CAT_WDT_CH = 5;
  localparam logic [3:0] CAT_DIV12_LAST = 4'hB;
  localparam logic [1:0] CAT_DIV4_LAST = 2'h3;
  localparam logic [15:0] CAT_CNT_RST = 16'h0000;
  localparam logic [15:0] CAT_CNT_MAX = 16'hFFFF;
  localparam logic [7:0] CAT_BYTE_RST = 8'h00;
  localparam logic [1:0] CAT_CLSEL_RST = 2'h0;
  localparam logic CAT_WDT_RST = 1'b1;
  localparam logic CAT_IDLE_RST = 1'b0;

  typedef enum logic [2:0] {
    TB_SYS_DIV12 = 3'b000,
    TB_SYS_DIV4 = 3'b001,
    TB_TMR0_OVF = 3'b010,
    TB_EXT_FALL = 3'b011,
    TB_SYS = 3'b100,
    TB_XOSC_DIV8 = 3'b101,
    TB_LFO_DIV8 = 3'b110,
    TB_RESERVED = 3'b111
  } cat_timebase_t;

  // per-channel setup as the channel sees it
  typedef struct packed {
    logic capPos;
    logic capNeg;
    logic matchEn;
    logic toggleEn;
    logic [15:0] compareValue;
  } cat_chan_cfg_t;

  localparam cat_chan_cfg_t CAT_CHAN_CFG_RST = '{1'b0, 1'b0, 1'b0, 1'b0, 16'h0000};
endpackage

//--- tb/cat_counter_array_test.sv
// self-checking bench for the counter array timebase block
`timescale 1ns/1ps
`default_nettype none
module cat_counter_array_test
  import cat_pkg::*;
;
  logic clk, srst, timer0Overflow, externalCountInput, xoscDiv8, lfoDiv8, cpuIdle, cfgLoad;
  logic [2:0] timebaseSelect;
  logic [1:0] cycleLengthSel;
  logic idleSuspendCtrl, watchdogDisable, overflowIrqEnable, intermediateOverflowIrqEnable;
  logic globalIrqEnable, counterArrayIrqEnable, overflowFlagClear, intermediateFlagClear;
  logic readLowByte, readHighByte, counterOverflowFlag, intermediateOverflowFlag;
  logic irqRequest, cpuIrq, watchdogActive;
  logic watchdogReset;
  logic [5:0] channelIoOut;
  logic [5:0][15:0] channelCapture;
  logic [5:0] channelIrqEnable, channelFlagClear, channelIoIn, channelEventFlag;
  logic [7:0] counterLowByte, counterHighByte;
  logic [7:0] lfsr;
  logic [15:0] d;
  cat_chan_cfg_t [5:0] channelCfg;
  int num_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  int e;
  int x;

  cat_counter_array i_cat_counter_array (
    .clk, .srst, .timer0Overflow, .externalCountInput, .xoscDiv8, .lfoDiv8, .cpuIdle,
    .cfgLoad, .timebaseSelect, .idleSuspendCtrl, .cycleLengthSel, .watchdogDisable,
    .overflowIrqEnable, .intermediateOverflowIrqEnable, .channelIrqEnable, .globalIrqEnable,
    .counterArrayIrqEnable, .overflowFlagClear, .intermediateFlagClear, .channelFlagClear,
    .readLowByte, .readHighByte, .channelCfg, .channelIoIn, .counterLowByte, .counterHighByte,
    .counterOverflowFlag, .intermediateOverflowFlag, .channelEventFlag, .channelIoOut,
    .channelCapture, .irqRequest, .cpuIrq, .watchdogActive, .watchdogReset
  );

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // periodic sources: t0 every 5, ext falls every 6, oscillators rise every 8
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    timer0Overflow <= (cyc % 5 == 0);
    externalCountInput <= 1'((cyc / 3) % 2);
    xoscDiv8 <= 1'((cyc / 4) % 2);
    lfoDiv8 <= 1'(((cyc + 2) / 4) % 2);
  end

  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  function automatic int expD(input logic [2:0] tb, input int n);
    case (tb)
      TB_SYS_DIV12: return n / 12;
      TB_SYS_DIV4: return n / 4;
      TB_TMR0_OVF: return n / 5;
      TB_EXT_FALL: return n / 6;
      TB_SYS: return n;
      TB_XOSC_DIV8, TB_LFO_DIV8: return n / 8;
      default: return 0;
    endcase
  endfunction

  task automatic give_verdict;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkBit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("FAIL at %0t: got %b expected %b", $time, got, exp);
    end
  endtask

  // x-safe range compare for count deltas
  task automatic chkIn(input logic [15:0] got, input int lo, input int hi);
    comparisons++;
    if ((^got === 1'bx) || int'(got) < lo || int'(got) > hi)
    begin
      num_errors++;
      $display("FAIL at %0t: got %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // low then high read; value is the count at the low-read edge
  task automatic rd(output logic [15:0] v);
    @(posedge clk);
    readLowByte <= 1'b1;
    @(posedge clk);
    readLowByte <= 1'b0;
    readHighByte <= 1'b1;
    @(posedge clk);
    readHighByte <= 1'b0;
    step(1);
    v = {counterHighByte, counterLowByte};
  endtask

  task automatic meas(output logic [15:0] dv, output int n);
    logic [15:0] a;
    logic [15:0] b;
    lfsr = nxt(lfsr);
    n = 40 + int'(lfsr[5:0]);
    rd(a);
    step(n);
    rd(b);
    dv = b - a;
    n = n + 4;
  endtask

  task automatic load(input logic [2:0] tb, input logic idle, input logic [1:0] cls);
    @(posedge clk);
    timebaseSelect <= tb;
    idleSuspendCtrl <= idle;
    cycleLengthSel <= cls;
    cfgLoad <= 1'b1;
    @(posedge clk);
    cfgLoad <= 1'b0;
    #1;
  endtask

  task automatic clr(input logic o, input logic i, input logic [5:0] c);
    @(posedge clk);
    overflowFlagClear <= o;
    intermediateFlagClear <= i;
    channelFlagClear <= c;
    @(posedge clk);
    overflowFlagClear <= 1'b0;
    intermediateFlagClear <= 1'b0;
    channelFlagClear <= 6'h00;
    #1;
  endtask

  // clear, then expect the flag to stay low until the predicted wrap and rise just after
  task automatic wrapChk(input int bits);
    logic [15:0] v;
    int m;
    int r;
    clr(bits == 16, bits != 16, 6'h00);
    rd(v);
    m = 1 << bits;
    r = m - 1 - (int'(v) % m);
    // a wrap on or just after the clear edge leaves the flag set, so no low check then
    if (r > 12 && r < m - 2)
    begin
      step(r - 6);
      chkBit(bits == 16 ? counterOverflowFlag : intermediateOverflowFlag, 1'b0);
      step(8);
    end
    else
      step(r + 4);
    chkBit(bits == 16 ? counterOverflowFlag : intermediateOverflowFlag, 1'b1);
  endtask

  initial
  begin
    srst = 1'b1;
    {cpuIdle, cfgLoad, timebaseSelect, idleSuspendCtrl, cycleLengthSel, watchdogDisable} = '0;
    {overflowIrqEnable, intermediateOverflowIrqEnable, channelIrqEnable, globalIrqEnable} = '0;
    {counterArrayIrqEnable, overflowFlagClear, intermediateFlagClear, channelFlagClear} = '0;
    {readLowByte, readHighByte, channelCfg, channelIoIn} = '0;
    lfsr = 8'h26;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    step(1);
    chkBit(watchdogActive, 1'b1);
    chk(16'({counterOverflowFlag, intermediateOverflowFlag, irqRequest, cpuIrq, channelEventFlag}), 16'h0000);
    // load under watchdog lock must be ignored, so counting goes on
    load(TB_RESERVED, 1'b0, 2'h0);
    meas(d, e);
    chkIn(d, 1, e);
    @(posedge clk);
    watchdogDisable <= 1'b1;
    @(posedge clk);
    watchdogDisable <= 1'b0;
    step(2);
    chkBit(watchdogActive, 1'b0);
    for (int c = 0; c < 8; c++)
    begin
      load(3'(c), 1'b0, 2'h0);
      meas(d, e);
      x = expD(3'(c), e);
      chkIn(d, x - ((c == 4 || c == 7) ? 0 : 2), x + ((c == 4 || c == 7) ? 0 : 2));
    end
    @(posedge clk);
    cpuIdle <= 1'b1;
    load(TB_SYS, 1'b1, 2'h0);
    meas(d, e);
    chk(d, 16'h0000);
    load(TB_SYS, 1'b0, 2'h0);
    meas(d, e);
    chk(d, 16'(e));
    @(posedge clk);
    cpuIdle <= 1'b0;
    load(TB_SYS, 1'b1, 2'h0);
    meas(d, e);
    chk(d, 16'(e));
    for (int s = 0; s < 4; s++)
    begin
      load(TB_SYS, 1'b0, 2'(s));
      wrapChk(8 + s);
    end
    wrapChk(16);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk);
      {overflowIrqEnable, globalIrqEnable, counterArrayIrqEnable} <= 3'(i);
      step(3);
      chkBit(irqRequest, i[2]);
      chkBit(cpuIrq, i == 7);
    end
    chkBit(counterOverflowFlag, 1'b1);
    clr(1'b1, 1'b0, 6'h00);
    step(2);
    chk(16'({counterOverflowFlag, irqRequest}), 16'h0000);
    @(posedge clk);
    intermediateOverflowIrqEnable <= 1'b1;
    step(2060);
    chkBit(irqRequest, 1'b1);
    @(posedge clk);
    intermediateOverflowIrqEnable <= 1'b0;
    for (int k = 0; k < 6; k++)
    begin
      lfsr = nxt(lfsr);
      @(posedge clk);
      channelCfg[k].capPos <= 1'b1;
      channelIrqEnable <= lfsr[0] ? 6'(1 << k) : 6'h00;
      // line edge is sampled four counts after the low-read edge
      rd(d);
      @(posedge clk);
      channelIoIn[k] <= 1'b1;
      step(4);
      chk(16'(channelEventFlag), 16'(1 << k));
      chk(channelCapture[k], d + 16'h0004);
      chk(16'({irqRequest, cpuIrq}), 16'({lfsr[0], lfsr[0]}));
      @(posedge clk);
      channelCfg[k].capPos <= 1'b0;
      channelIoIn[k] <= 1'b0;
      clr(1'b0, 1'b0, 6'(1 << k));
      step(1);
      chk(16'(channelEventFlag), 16'h0000);
    end
    // compare match sixteen counts after the low-read edge toggles the line
    rd(d);
    @(posedge clk);
    channelCfg[0] <= '{1'b0, 1'b0, 1'b1, 1'b1, d + 16'h0010};
    step(20);
    chk(16'(channelIoOut), 16'h0001);
    chk(16'(channelEventFlag), 16'h0001);
    // second reset mid-run re-arms the watchdog on channel 5
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    step(1);
    chkBit(watchdogActive, 1'b1);
    chk(16'({channelIoOut, channelEventFlag}), 16'h0000);
    @(posedge clk);
    channelCfg[5].capPos <= 1'b1;
    @(posedge clk);
    channelIoIn[5] <= 1'b1;
    step(2);
    chkBit(watchdogReset, 1'b1);
    step(1);
    chkBit(watchdogReset, 1'b0);
    give_verdict();
  end

  // full run stays under 80k cycles
  initial
  begin
    #(95000 * 8);
    num_errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
